// File: rtl/hdlc_tx_pkg.sv
`default_nettype none
package hdlc_tx_pkg;
  // Link framing constants
  localparam logic [7:0]  FLAG_BYTE     = 8'h7e;
  localparam int          MAX_PAYLOAD   = 512;
  localparam logic [9:0]  MAX_PAYLOAD_W = 10'h200;
  localparam logic [2:0]  STUFF_LIMIT   = 3'h5;
  // Check field: x^16+x^12+x^5+1, all-ones preset
  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_PRESET    = 16'hffff;
  // Scrambler taps (output xor stage 3 and stage 20)
  localparam int          SCR_LEN       = 20;
  localparam int          SCR_TAP_A     = 2;
  localparam int          SCR_TAP_B     = 19;
  // Timing: idle close of a partly filled frame
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          IDLE_CLOSE_NS = 20000;
  localparam int          IDLE_CLOSE_CYC = (IDLE_CLOSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] IDLE_CLOSE_W  = 12'(IDLE_CLOSE_CYC);
  // Byte buffer ahead of the framer
  localparam int          BYTE_W        = 8;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          IDX_W         = 10;

  typedef enum logic [1:0] {ST_FLAG, ST_DATA, ST_CRC} tx_state_type;

  typedef struct packed {
    logic valid;
    logic data;
  } line_bit_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_type;
endpackage
`default_nettype wire

// File: rtl/byte_fifo.sv
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0]      count_ff, nxt_count;
  logic             ready_ff, nxt_ready;
  logic             push, pop;

  // Ready is registered so the source never sees a combinational path
  always_comb begin
    push       = in_valid_i & ready_ff;
    pop        = out_valid_o & out_ready_i;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count  = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    nxt_ready  = nxt_count != FULL_CNT;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      ready_ff  <= nxt_ready;
    end
  end

  // Storage has no reset; only occupied words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  assign in_ready_o  = ready_ff;
  assign out_valid_o = count_ff != '0;
  assign out_data_o  = mem[rd_ptr_ff];
endmodule
`default_nettype wire

// File: rtl/hdlc_serial_tx_framer.sv
// Functional notes
// - With no payload waiting, keep the link busy sending flags as empty frames.
// - Frame payload never exceeds 512 bytes; a full frame is closed.
// - A partly filled frame idle for 20us is closed and sent short.
// - Non-empty frames get a 16-bit check field; empty frames get none.
// - Payload bytes go onto the bit stream most significant bit first.
// - The framer's own shift register converts bytes to single bits as it frames them.
// - The framed stream is scrambled before the convolutional encoder.
`default_nettype none
module hdlc_serial_tx_framer (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       BYTE_VALID_I,
  input  wire logic [7:0] BYTE_DATA_I,
  output logic            BYTE_READY_O,
  input  wire logic       BIT_REQ_I,
  output logic            SCR_BIT_O,
  output logic            SCR_VALID_O
);
  logic                      fifo_valid, fifo_pop;
  logic [7:0]                fifo_data;
  logic [7:0]                frame_mem [hdlc_tx_pkg::MAX_PAYLOAD];
  // Collection side
  logic [9:0]                wr_cnt_ff, nxt_wr_cnt;
  logic [11:0]               idle_cnt_ff, nxt_idle_cnt;
  logic                      frame_rdy_ff, nxt_frame_rdy;
  logic                      tx_done;
  // Transmit side
  hdlc_tx_pkg::tx_state_type st_ff, nxt_st;
  logic [7:0]                sh_ff, nxt_sh;
  logic [2:0]                bit_cnt_ff, nxt_bit_cnt;
  logic [2:0]                ones_ff, nxt_ones;
  logic [9:0]                idx_ff, nxt_idx;
  logic [15:0]               crc_ff, nxt_crc;
  logic                      crc_lo_ff, nxt_crc_lo;
  logic [19:0]               scr_ff, nxt_scr;
  hdlc_tx_pkg::line_bit_type out_ff, nxt_out;
  logic                      stuff, adv, raw_bit, fb;

  // Byte source is buffered; back-pressure reaches BYTE_READY_O
  byte_fifo #(
    .WIDTH (hdlc_tx_pkg::BYTE_W),
    .DEPTH (hdlc_tx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .in_valid_i  (BYTE_VALID_I),
    .in_data_i   (BYTE_DATA_I),
    .in_ready_o  (BYTE_READY_O),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (!frame_rdy_ff)
  );

  // Collect bytes into the frame buffer; the buffer is locked while it is sent
  always_comb begin
    fifo_pop      = fifo_valid & !frame_rdy_ff;
    nxt_wr_cnt    = wr_cnt_ff;
    nxt_idle_cnt  = idle_cnt_ff;
    nxt_frame_rdy = frame_rdy_ff;
    if (frame_rdy_ff) begin
      if (tx_done) begin
        nxt_frame_rdy = 1'b0;
        nxt_wr_cnt    = '0;
        nxt_idle_cnt  = '0;
      end
    end else if (fifo_pop) begin
      nxt_wr_cnt   = wr_cnt_ff + 10'h001;
      nxt_idle_cnt = '0;
      if (nxt_wr_cnt == hdlc_tx_pkg::MAX_PAYLOAD_W) begin
        nxt_frame_rdy = 1'b1;
      end
    end else if (wr_cnt_ff != '0) begin
      nxt_idle_cnt = idle_cnt_ff + 12'h001;
      if (nxt_idle_cnt == hdlc_tx_pkg::IDLE_CLOSE_W) begin
        nxt_frame_rdy = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_cnt_ff    <= '0;
      idle_cnt_ff  <= '0;
      frame_rdy_ff <= 1'b0;
    end else begin
      wr_cnt_ff    <= nxt_wr_cnt;
      idle_cnt_ff  <= nxt_idle_cnt;
      frame_rdy_ff <= nxt_frame_rdy;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (fifo_pop) begin
      frame_mem[wr_cnt_ff[8:0]] <= fifo_data;
    end
  end

  // One line bit per request; a stuffed zero holds the rest of the stream
  always_comb begin
    stuff       = ones_ff == hdlc_tx_pkg::STUFF_LIMIT; // Also breaks a check-field run of ones before the flag
    adv         = BIT_REQ_I & !stuff;
    nxt_st      = st_ff;
    nxt_sh      = sh_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_ones    = ones_ff;
    nxt_idx     = idx_ff;
    nxt_crc     = crc_ff;
    nxt_crc_lo  = crc_lo_ff;
    tx_done     = 1'b0;
    fb          = 1'b0;
    case (st_ff)
      hdlc_tx_pkg::ST_FLAG: raw_bit = hdlc_tx_pkg::FLAG_BYTE[3'h7 - bit_cnt_ff];
      hdlc_tx_pkg::ST_DATA: raw_bit = sh_ff[7];
      hdlc_tx_pkg::ST_CRC:  raw_bit = crc_ff[15];
      default:              raw_bit = 1'b1;
    endcase
    if (BIT_REQ_I && stuff) begin
      raw_bit  = 1'b0;
      nxt_ones = '0;
    end else if (adv) begin
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      nxt_ones    = (raw_bit && st_ff != hdlc_tx_pkg::ST_FLAG) ? ones_ff + 3'h1 : 3'h0;
      case (st_ff)
        hdlc_tx_pkg::ST_FLAG: begin
          // Back-to-back flags are the empty frames of an idle link
          if (bit_cnt_ff == 3'h7 && frame_rdy_ff) begin
            nxt_st  = hdlc_tx_pkg::ST_DATA;
            nxt_sh  = frame_mem[0];
            nxt_idx = 10'h001;
            nxt_crc = hdlc_tx_pkg::CRC_PRESET;
          end
        end
        hdlc_tx_pkg::ST_DATA: begin
          fb      = crc_ff[15] ^ raw_bit;
          nxt_crc = {crc_ff[14:0], 1'b0} ^ (fb ? hdlc_tx_pkg::CRC_POLY : 16'h0000);
          nxt_sh  = {sh_ff[6:0], 1'b0};
          if (bit_cnt_ff == 3'h7) begin
            if (idx_ff == wr_cnt_ff) begin
              nxt_st     = hdlc_tx_pkg::ST_CRC;
              nxt_crc_lo = 1'b0;
            end else begin
              nxt_sh  = frame_mem[idx_ff[8:0]];
              nxt_idx = idx_ff + 10'h001;
            end
          end
        end
        hdlc_tx_pkg::ST_CRC: begin
          nxt_crc = {crc_ff[14:0], 1'b0};
          if (bit_cnt_ff == 3'h7) begin
            nxt_crc_lo = 1'b1;
            if (crc_lo_ff) begin
              nxt_st  = hdlc_tx_pkg::ST_FLAG;
              tx_done = 1'b1;
            end
          end
        end
        default: nxt_st = hdlc_tx_pkg::ST_FLAG;
      endcase
    end
    // Self-synchronising scrambler so the far end needs no alignment
    nxt_scr = scr_ff;
    nxt_out = '{valid: BIT_REQ_I, data: out_ff.data};
    if (BIT_REQ_I) begin
      nxt_out.data = raw_bit ^ scr_ff[hdlc_tx_pkg::SCR_TAP_A] ^ scr_ff[hdlc_tx_pkg::SCR_TAP_B];
      nxt_scr      = {scr_ff[18:0], nxt_out.data};
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_ff      <= hdlc_tx_pkg::ST_FLAG;
      sh_ff      <= '0;
      bit_cnt_ff <= '0;
      ones_ff    <= '0;
      idx_ff     <= '0;
      crc_ff     <= hdlc_tx_pkg::CRC_PRESET;
      crc_lo_ff  <= 1'b0;
      scr_ff     <= '0;
      out_ff     <= '0;
    end else begin
      st_ff      <= nxt_st;
      sh_ff      <= nxt_sh;
      bit_cnt_ff <= nxt_bit_cnt;
      ones_ff    <= nxt_ones;
      idx_ff     <= nxt_idx;
      crc_ff     <= nxt_crc;
      crc_lo_ff  <= nxt_crc_lo;
      scr_ff     <= nxt_scr;
      out_ff     <= nxt_out;
    end
  end

  assign SCR_BIT_O   = out_ff.data;
  assign SCR_VALID_O = out_ff.valid;

  // Checks
  sequence flag_end_s;
    adv && st_ff == hdlc_tx_pkg::ST_FLAG && bit_cnt_ff == 3'h7;
  endsequence
  sequence data_last_s;
    adv && st_ff == hdlc_tx_pkg::ST_DATA && bit_cnt_ff == 3'h7 && idx_ff == wr_cnt_ff;
  endsequence

  a_idle_flags: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    flag_end_s and !frame_rdy_ff |=> st_ff == hdlc_tx_pkg::ST_FLAG && bit_cnt_ff == 3'h0)
    else $error("idle link left the flag pattern");
  a_payload_bound: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    wr_cnt_ff <= hdlc_tx_pkg::MAX_PAYLOAD_W && (wr_cnt_ff != hdlc_tx_pkg::MAX_PAYLOAD_W || frame_rdy_ff))
    else $error("frame payload over limit");
  a_idle_close: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !frame_rdy_ff && !fifo_valid && wr_cnt_ff != '0 && idle_cnt_ff == hdlc_tx_pkg::IDLE_CLOSE_W - 12'h001
    |=> frame_rdy_ff && $stable(wr_cnt_ff))
    else $error("idle frame not closed after timeout");
  a_crc_follows: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    data_last_s |=> st_ff == hdlc_tx_pkg::ST_CRC && !crc_lo_ff)
    else $error("check field missing after payload");
  a_crc_source: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    $changed(st_ff) && st_ff == hdlc_tx_pkg::ST_CRC |-> $past(st_ff) == hdlc_tx_pkg::ST_DATA)
    else $error("check field outside a payload frame");
  a_msb_first: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    flag_end_s and frame_rdy_ff |=> sh_ff == $past(frame_mem[0]) && raw_bit == sh_ff[7])
    else $error("first payload bit is not the msb");
  a_byte_fetch: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    adv && st_ff == hdlc_tx_pkg::ST_DATA && bit_cnt_ff == 3'h7 && idx_ff != wr_cnt_ff
    |=> idx_ff == $past(idx_ff) + 10'h001 && bit_cnt_ff == 3'h0)
    else $error("serializer did not fetch next byte");
  a_scramble: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    BIT_REQ_I |=> SCR_VALID_O && SCR_BIT_O == ($past(raw_bit) ^ $past(scr_ff[2]) ^ $past(scr_ff[19])))
    else $error("scrambler output wrong");
  a_zero_stuff: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    BIT_REQ_I && stuff |-> raw_bit == 1'b0 ##1 ones_ff == 3'h0 && $stable(bit_cnt_ff))
    else $error("stuffed zero missing");
  a_crc_preset: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    $rose(st_ff == hdlc_tx_pkg::ST_DATA) |-> crc_ff == hdlc_tx_pkg::CRC_PRESET)
    else $error("check register not preset");
endmodule
`default_nettype wire

// File: bench/hdlc_rx_model.sv
`default_nettype none
module hdlc_rx_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic bit_i,
  input  wire logic valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] scr_ff;
  logic [7:0]  sh_ff;
  int          ones;
  int          flag_cnt = 0;
  int          bad_cnt  = 0;
  logic        bq[$];
  logic [7:0]  good_q[$];
  int          lens[$];

  // Closes one frame: bytes msb first, check field last; a failing frame is dropped whole
  task automatic take_frame();
    logic [15:0] crc;
    logic [15:0] rx;
    logic [7:0]  b;
    logic [7:0]  tmp[$];
    int          n;
    n = bq.size();
    crc = 16'hffff;
    rx = '0;
    b = '0;
    if (n % 8 != 0 || n < 24) begin
      bad_cnt++;
    end else begin
      for (int i = 0; i < n; i++) begin
        if (i < n - 16) begin
          crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ bq[i]) ? 16'h1021 : 16'h0000);
          b = {b[6:0], bq[i]};
          if (i % 8 == 7) tmp.push_back(b);
        end else begin
          rx = {rx[14:0], bq[i]};
        end
      end
      if (crc !== rx) begin
        bad_cnt++;
      end else begin
        good_q = {good_q, tmp};
        lens.push_back(n / 8 - 2);
      end
    end
    bq.delete();
  endtask

  // Descramble, split on flags, strip stuffed zeros; the flag's leading seven bits are undone at the flag
  always @(posedge clk_i or negedge rst_b_i) begin
    logic d;
    if (!rst_b_i) begin
      scr_ff = '0;
      sh_ff = '0;
      ones = 0;
      bq.delete();
    end else if (valid_i) begin
      d = bit_i ^ scr_ff[2] ^ scr_ff[19];
      scr_ff = {scr_ff[18:0], bit_i};
      sh_ff = {sh_ff[6:0], d};
      if (sh_ff == 8'h7e) begin
        flag_cnt++;
        if (bq.size() >= 7) repeat (7) void'(bq.pop_back());
        ones = 0;
        if (bq.size() != 0) take_frame();
      end else if (ones == 5 && !d) begin
        ones = 0;
      end else begin
        bq.push_back(d);
        ones = d ? ones + 1 : 0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/hdlc_serial_tx_framer_test.sv
`default_nettype none
module hdlc_serial_tx_framer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk    = 1'b0;
  logic       rst_b      = 1'b0;
  logic       byte_valid = 1'b0;
  logic [7:0] byte_data  = 8'h00;
  logic       bit_req    = 1'b0;
  logic       req_en     = 1'b0;
  logic       req_d      = 1'b0;
  logic       byte_ready;
  logic       scr_bit;
  logic       scr_valid;
  int         err_total   = 0;
  int         check_count = 0;
  int         seed        = 32'h8609defe;
  int         taken;
  logic [7:0] exp_q[$];
  int         exp_lens[$];

  always #2.5 ref_clk = ~ref_clk;

  hdlc_serial_tx_framer dut (
    .REF_CLK_I    (ref_clk),
    .RST_B_I      (rst_b),
    .BYTE_VALID_I (byte_valid),
    .BYTE_DATA_I  (byte_data),
    .BYTE_READY_O (byte_ready),
    .BIT_REQ_I    (bit_req),
    .SCR_BIT_O    (scr_bit),
    .SCR_VALID_O  (scr_valid)
  );

  hdlc_rx_model rx (
    .clk_i   (ref_clk),
    .rst_b_i (rst_b),
    .bit_i   (scr_bit),
    .valid_i (scr_valid)
  );

  // Random requests stand in for a bursty encoder, so the far side runs both prompt and slow
  always @(negedge ref_clk) bit_req <= req_en && (($random(seed) & 32'sh1) != 0);
  always @(posedge ref_clk) req_d <= bit_req;
  // Every request answered by a one-cycle pulse on the next edge
  always @(negedge ref_clk) if (rst_b) check(32'(scr_valid), 32'(req_d));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Valid and data held until an edge with ready high takes the byte
  task automatic send_byte(input logic [7:0] b);
    int n;
    n = 0;
    byte_valid = 1'b1;
    byte_data = b;
    while (byte_ready !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 20000) begin err_total++; close_out(); end
    end
    @(negedge ref_clk);
    exp_q.push_back(b);
  endtask

  task automatic send_burst(input int cnt);
    repeat (cnt) send_byte(8'($random(seed)));
    byte_valid = 1'b0;
  endtask

  task automatic wait_frames(input int k);
    int n;
    n = 0;
    while (rx.lens.size() < k) begin
      @(negedge ref_clk);
      n++;
      if (n > 60000) begin err_total++; close_out(); end
    end
  endtask

  // Reference frames against what the far side accepted, length then bytes
  task automatic compare_frames();
    while (exp_lens.size() != 0) check(32'(rx.lens.pop_front()), 32'(exp_lens.pop_front()));
    while (exp_q.size() != 0) check(32'(rx.good_q.pop_front()), 32'(exp_q.pop_front()));
    check(32'(rx.good_q.size()), 32'h0);
  endtask

  initial begin
    repeat (12) @(negedge ref_clk);
    check(32'(byte_ready), 32'h0);
    rst_b = 1'b1;
    req_en = 1'b1;
    @(negedge ref_clk);
    check(32'(byte_ready), 32'h1);
    // Idle link: flags only, nothing delivered
    repeat (2000) @(negedge ref_clk);
    check(32'(rx.flag_cnt > 20), 32'h1);
    check(32'(rx.lens.size()), 32'h0);
    // Short frame must not close before the idle time runs out
    send_burst(3);
    exp_lens.push_back(3);
    repeat (3900) @(negedge ref_clk);
    check(32'(rx.lens.size()), 32'h0);
    wait_frames(1);
    compare_frames();
    // Stalled encoder: one full frame held, then the byte buffer fills and refuses
    req_en = 1'b0;
    taken = 0;
    while (byte_ready === 1'b1 && taken < 600) begin
      send_byte(8'($random(seed)));
      taken++;
    end
    byte_valid = 1'b0;
    check(32'(taken), 32'(hdlc_tx_pkg::MAX_PAYLOAD + hdlc_tx_pkg::FIFO_DEPTH));
    repeat (100) @(negedge ref_clk);
    check(32'(byte_ready), 32'h0);
    req_en = 1'b1;
    send_burst(530 - taken);
    exp_lens.push_back(512);
    exp_lens.push_back(18);
    wait_frames(2);
    compare_frames();
    check(32'(rx.bad_cnt), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
